/* rtl/odsc_top.v */
// Octal converter serial command decoder with AXI4-Lite status access
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "odsc_defines.vh"
module odsc_top (
   input wire aclk,                  // System clock, 100 MHz
   input wire aresetn,               // Synchronous reset, active low
   // Serial link
   input wire sclk,                  // Link serial clock
   input wire sync_n,                // Frame strobe, active low
   input wire sdin,                  // Serial data in
   output reg sdout,                 // Serial data out for chaining
   // Converter side
   output wire [95:0] dac_code,      // Output latches, channel 0 low
   output wire [7:0] pd_mask,        // Channel powered down
   output wire [15:0] pd_term,       // Termination code per channel
   output wire bias_shutdown,        // Global bias off
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,    // Write address
   input wire [2:0] s_axi_awprot,    // Write protection, unused
   input wire s_axi_awvalid,         // Write address valid
   output wire s_axi_awready,        // Write address ready
   input wire [31:0] s_axi_wdata,    // Write data
   input wire [3:0] s_axi_wstrb,     // Write strobes
   input wire s_axi_wvalid,          // Write data valid
   output wire s_axi_wready,         // Write data ready
   output reg [1:0] s_axi_bresp,     // Write response
   output reg s_axi_bvalid,          // Write response valid
   input wire s_axi_bready,          // Write response ready
   input wire [7:0] s_axi_araddr,    // Read address
   input wire [2:0] s_axi_arprot,    // Read protection, unused
   input wire s_axi_arvalid,         // Read address valid
   output wire s_axi_arready,        // Read address ready
   output reg [31:0] s_axi_rdata,    // Read data
   output reg [1:0] s_axi_rresp,     // Read response
   output reg s_axi_rvalid,          // Read data valid
   input wire s_axi_rready           // Read data ready
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Channel select to one-hot
   function [7:0] odsc_onehot;
      input [2:0] sel;
      begin
         odsc_onehot = 8'h01 << sel;
      end
   endfunction
   // Power-down nibble to termination code
   function [1:0] odsc_term;
      input [3:0] nib;
      begin
         case (nib)
            `ODSC_CMD_PD_HIZ: odsc_term = `ODSC_TERM_HIZ;
            `ODSC_CMD_PD_100K: odsc_term = `ODSC_TERM_100K;
            `ODSC_CMD_PD_2K5: odsc_term = `ODSC_TERM_2K5;
            default: odsc_term = `ODSC_TERM_ACTIVE;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [2:0] pin_lvl, pin_rise, pin_fall;
   wire sclk_fall, frame_low, frame_start, frame_end, exec, abort;
   wire flag, is_pd, do_write, do_read;
   wire [3:0] nib;
   wire [7:0] sel_hot, mask;
   wire [11:0] field;
   wire [95:0] code_flat;
   reg [15:0] shift_q, last_cmd_q, frames_q, aborts_q;
   reg [`ODSC_CNT_W-1:0] cnt_q, cnt_base, cnt_d;
   reg link_en_q, wtm_q, aw_hold_q, w_hold_q, rd_err, wr_err;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q, rd_val;
   reg [3:0] wstrb_q;

   // ----------------------------------------------------------------
   // Link pin synchronisers
   // ----------------------------------------------------------------
   // Pins: bit 2 clock, bit 1 strobe, bit 0 data
   odsc_link_sync #(
      .W(3)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({sclk, sync_n, sdin}),
      .pin_rst(3'h2),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );
   assign sclk_fall = pin_fall[2];
   assign frame_low = ~pin_lvl[1];
   assign frame_start = pin_fall[1];
   assign frame_end = pin_rise[1];

   // ----------------------------------------------------------------
   // Serial frame receiver
   // ----------------------------------------------------------------
   // Edge count restarts at strobe fall and saturates
   always @* begin
      cnt_base = frame_start ? `ODSC_CNT_ZERO : cnt_q;
      if (cnt_base == `ODSC_CNT_MAX) begin
         cnt_d = cnt_base;
      end else begin
         cnt_d = cnt_base + `ODSC_CNT_ONE;
      end
   end

   // Shift, count and chain output
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= 16'h0000;
         cnt_q <= `ODSC_CNT_ZERO;
         sdout <= 1'b0;
      end else begin
         if (frame_start) begin
            cnt_q <= `ODSC_CNT_ZERO;
            sdout <= 1'b0;
         end
         if (frame_low && sclk_fall && link_en_q) begin
            shift_q <= {shift_q[14:0], pin_lvl[0]};
            cnt_q <= cnt_d;
            if (cnt_d < `ODSC_EDGE_MARK) begin
               sdout <= 1'b0;
            end else if (cnt_d == `ODSC_EDGE_MARK) begin
               sdout <= 1'b1;
            end else begin
               // echo bit from fifteen edges back
               sdout <= shift_q[`ODSC_ECHO_TAP];
            end
         end
      end
   end
   assign exec = frame_end && link_en_q && (cnt_q >= `ODSC_EDGE_EXEC);
   assign abort = frame_end && link_en_q && (cnt_q < `ODSC_EDGE_EXEC);
   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   assign nib = shift_q[`ODSC_NIB_HI:`ODSC_NIB_LO];
   assign flag = shift_q[`ODSC_FLAG_BIT];
   assign sel_hot = odsc_onehot(shift_q[`ODSC_SEL_HI:`ODSC_SEL_LO]);
   assign mask = shift_q[`ODSC_MASK_HI:0];
   assign field = shift_q[`ODSC_CODE_HI:0];
   assign is_pd = flag && (nib >= `ODSC_CMD_PD_HIZ);
   // Mode register and last command
   always @(posedge aclk) begin
      if (!aresetn) begin
         wtm_q <= 1'b0;
         last_cmd_q <= 16'h0000;
      end else if (exec) begin
         last_cmd_q <= shift_q;
         if (nib == `ODSC_CMD_REG_ONLY) begin
            wtm_q <= 1'b0;
         end else if (nib == `ODSC_CMD_WRITE_THRU) begin
            wtm_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel code registers and output latches
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < `ODSC_NCH; ch = ch + 1) begin : g_ch
         reg [11:0] code_q, latch_q;
         reg [1:0] term_q;
         wire wr_code, ld_new, ld_old, pd_go;

         assign wr_code = exec && ((!flag && sel_hot[ch]) ||
            (nib == `ODSC_CMD_CHA_WRITE && ch == 0) || (nib == `ODSC_CMD_BROADCAST));
         assign ld_new = exec && ((!flag && sel_hot[ch] && wtm_q) ||
            (nib == `ODSC_CMD_CHA_WRITE && ch == 0) || (nib == `ODSC_CMD_BROADCAST));
         assign ld_old = exec && ((nib == `ODSC_CMD_UPD_SELECT && mask[ch]) ||
            (nib == `ODSC_CMD_CHA_WRITE && ch != 0));
         assign pd_go = exec && is_pd && mask[ch];

         // Per-channel state
         always @(posedge aclk) begin
            if (!aresetn) begin
               code_q <= 12'h000;
               latch_q <= 12'h000;
               term_q <= `ODSC_TERM_ACTIVE;
            end else begin
               if (wr_code) begin
                  code_q <= field;
               end
               if (ld_new) begin
                  latch_q <= field;
               end else if (ld_old) begin
                  latch_q <= code_q;
               end
               if (pd_go) begin
                  term_q <= odsc_term(nib);
               end else if (ld_new || ld_old) begin
                  term_q <= `ODSC_TERM_ACTIVE;
               end
            end
         end

         assign code_flat[ch*12 +: 12] = code_q;
         assign dac_code[ch*12 +: 12] = latch_q;
         assign pd_term[ch*2 +: 2] = term_q;
         assign pd_mask[ch] = (term_q != `ODSC_TERM_ACTIVE);
      end
   endgenerate

   // bias off only when all down
   assign bias_shutdown = &pd_mask;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
   assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

   // Writable offsets
   always @* begin
      case (awaddr_q)
         `ODSC_A_CTRL: wr_err = 1'b0;
         `ODSC_A_FRAMES: wr_err = 1'b0;
         `ODSC_A_ABORTS: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end
   // Address and data capture, response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ODSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `ODSC_RESP_SLVERR : `ODSC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control bit and frame counters
   always @(posedge aclk) begin
      if (!aresetn) begin
         link_en_q <= `ODSC_CTRL_RST;
         frames_q <= 16'h0000;
         aborts_q <= 16'h0000;
      end else begin
         if (do_write && awaddr_q == `ODSC_A_CTRL && wstrb_q[0]) begin
            link_en_q <= wdata_q[0];
         end
         // Event count wins over software clear
         if (exec) begin
            frames_q <= frames_q + 16'h0001;
         end else if (do_write && awaddr_q == `ODSC_A_FRAMES) begin
            frames_q <= 16'h0000;
         end
         if (abort) begin
            aborts_q <= aborts_q + 16'h0001;
         end else if (do_write && awaddr_q == `ODSC_A_ABORTS) begin
            aborts_q <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_read = s_axi_arvalid & s_axi_arready;

   // Read decode
   always @* begin
      rd_val = 32'h00000000;
      rd_err = 1'b0;
      case (s_axi_araddr[7:5])
         `ODSC_BANK_CODE: rd_val = {20'h00000, code_flat[s_axi_araddr[4:2]*12 +: 12]};
         `ODSC_BANK_LATCH: rd_val = {20'h00000, dac_code[s_axi_araddr[4:2]*12 +: 12]};
         default: begin
            case ({s_axi_araddr[7:2], 2'b00})
               `ODSC_A_CTRL: rd_val = {31'h00000000, link_en_q};
               `ODSC_A_STATUS: rd_val = {16'h0000, pd_mask, 5'h00, frame_low,
                  bias_shutdown, wtm_q};
               `ODSC_A_LASTCMD: rd_val = {16'h0000, last_cmd_q};
               `ODSC_A_FRAMES: rd_val = {16'h0000, frames_q};
               `ODSC_A_ABORTS: rd_val = {16'h0000, aborts_q};
               `ODSC_A_PDTERM: rd_val = {16'h0000, pd_term};
               default: rd_err = 1'b1;
            endcase
         end
      endcase
   end

   // Registered read answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ODSC_RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_err ? `ODSC_RESP_SLVERR : `ODSC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // odsc_top

/* rtl/odsc_defines.vh */
// Constants for the octal converter serial command decoder
`ifndef ODSC_DEFINES_VH
`define ODSC_DEFINES_VH

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define ODSC_CMD_W 16
`define ODSC_CNT_W 6
`define ODSC_CNT_ZERO 6'h00
`define ODSC_CNT_ONE 6'h01
`define ODSC_CNT_MAX 6'h3F
`define ODSC_EDGE_ABORT 6'h0F
`define ODSC_EDGE_MARK 6'h0F
`define ODSC_EDGE_EXEC 6'h10
`define ODSC_ECHO_TAP 14
`define ODSC_NCH 8
`define ODSC_CODE_W 12

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define ODSC_FLAG_BIT 15
`define ODSC_NIB_HI 15
`define ODSC_NIB_LO 12
`define ODSC_SEL_HI 14
`define ODSC_SEL_LO 12
`define ODSC_CODE_HI 11
`define ODSC_MASK_HI 7
`define ODSC_CMD_REG_ONLY 4'h8
`define ODSC_CMD_WRITE_THRU 4'h9
`define ODSC_CMD_UPD_SELECT 4'hA
`define ODSC_CMD_CHA_WRITE 4'hB
`define ODSC_CMD_BROADCAST 4'hC
`define ODSC_CMD_PD_HIZ 4'hD
`define ODSC_CMD_PD_100K 4'hE
`define ODSC_CMD_PD_2K5 4'hF

// Output termination codes per channel
`define ODSC_TERM_ACTIVE 2'h0
`define ODSC_TERM_HIZ 2'h1
`define ODSC_TERM_100K 2'h2
`define ODSC_TERM_2K5 2'h3

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ODSC_ADDR_W 8
`define ODSC_A_CTRL 8'h00
`define ODSC_A_STATUS 8'h04
`define ODSC_A_LASTCMD 8'h08
`define ODSC_A_FRAMES 8'h0C
`define ODSC_A_ABORTS 8'h10
`define ODSC_A_PDTERM 8'h14
`define ODSC_BANK_CODE 3'h1
`define ODSC_BANK_LATCH 3'h2
`define ODSC_CTRL_RST 1'b1
`define ODSC_RESP_OKAY 2'h0
`define ODSC_RESP_SLVERR 2'h2

`endif

/* rtl/odsc_link_sync.v */
// Two-flop synchronisers with edge detection for the serial link pins
`timescale 1ns/1ps
module odsc_link_sync #(
   parameter W = 3
) (
   input wire aclk,            // System clock
   input wire aresetn,         // Synchronous reset, active low
   input wire [W-1:0] pin_in,  // Raw link pins
   input wire [W-1:0] pin_rst, // Levels taken during reset
   output wire [W-1:0] level,  // Synchronised level
   output wire [W-1:0] rise,   // One-cycle rising pulse
   output wire [W-1:0] fall    // One-cycle falling pulse
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   // First stage is read by the second stage only
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= pin_rst;
         sync_q <= pin_rst;
         prev_q <= pin_rst;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge pulses from settled stages
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule // odsc_link_sync

/* tb/odsc_checker_sva.sv */
// Port-level assertion checker for the octal converter serial command decoder
`timescale 1ns/1ps
module odsc_checker (
   input wire aclk,            // System clock
   input wire aresetn,         // Synchronous reset, active low
   input wire sclk,            // Link serial clock
   input wire sync_n,          // Frame strobe, active low
   input wire sdin,            // Serial data in
   input wire sdout,           // Chain data out
   input wire [95:0] dac_code, // Output latches
   input wire [7:0] pd_mask,   // Powered-down channels
   input wire [15:0] pd_term,  // Termination codes
   input wire bias_shutdown,   // Global bias off
   input wire [7:0] s_axi_awaddr, // Write address
   input wire [31:0] s_axi_wdata, // Write data
   input wire s_axi_awvalid,   // Write address valid
   input wire s_axi_awready,   // Write address ready
   input wire s_axi_wvalid,    // Write data valid
   input wire s_axi_wready,    // Write data ready
   input wire s_axi_bvalid     // Write response valid
);
   // ------------------------------------------------------------
   // Link edge tracking
   // ------------------------------------------------------------
   logic sclk_q;
   logic [5:0] fcnt_q;
   logic [15:0] hist_q;
   logic [7:0] since_q;
   logic en_q;

   // Falls in frame, received bits, cycles since strobe high
   always @(posedge aclk) begin
      if (!aresetn) begin
         sclk_q <= 1'h0;
         fcnt_q <= 6'h00;
         hist_q <= 16'h0000;
         since_q <= 8'hFF;
         en_q <= 1'h1;
      end else begin
         sclk_q <= sclk;
         // Link enable follows control writes
         if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
            s_axi_awaddr[7:2] == 6'h00) begin
            en_q <= s_axi_wdata[0];
         end
         if (sync_n) begin
            fcnt_q <= 6'h00;
         end else if (sclk_q && !sclk && fcnt_q != 6'h3F) begin
            fcnt_q <= fcnt_q + 6'h01;
         end
         if (!sync_n && sclk_q && !sclk) begin
            hist_q <= {hist_q[14:0], sdin};
         end
         if (!sync_n) begin
            since_q <= 8'h00;
         end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_link_rise;
      $rose(sclk) && !sync_n;
   endsequence
   sequence s_short_frame;
      $rose(sync_n) && fcnt_q < 6'h0F;
   endsequence
   sequence s_outputs_hold;
      ($stable(dac_code) && $stable(pd_term)) [*8];
   endsequence

   chk_lead_low: assert property (s_link_rise ##0 (fcnt_q <= 6'h0E) |-> !sdout)
      else $error("chain output not low in lead-in");
   chk_mark_bit: assert property (s_link_rise ##0 (en_q && fcnt_q == 6'h0F) |-> sdout)
      else $error("chain output not high after edge fifteen");
   chk_echo_bits: assert property (
      s_link_rise ##0 (en_q && fcnt_q >= 6'h10) |-> sdout == hist_q[15])
      else $error("chain output does not echo input");
   chk_short_abort: assert property (s_short_frame |=> s_outputs_hold)
      else $error("short frame changed outputs");
   chk_exec_window: assert property (
      !$stable(dac_code) || !$stable(pd_term) |-> since_q >= 8'h01 && since_q <= 8'h0C)
      else $error("outputs changed away from strobe rise");
   chk_reset_clear: assert property (
      $rose(aresetn) |-> dac_code == 96'h0 && pd_term == 16'h0 && !sdout)
      else $error("outputs not cleared by reset");
   chk_pd_keeps: assert property ((pd_mask & ~$past(pd_mask)) != 8'h00 |-> $stable(dac_code))
      else $error("latch changed on power-down");
   chk_bias_down: assert property (bias_shutdown == (pd_mask == 8'hFF))
      else $error("bias shutdown wrong for power-down set");
   // Write answer two cycles after take
   chk_write_resp: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
endmodule // odsc_checker

/* tb/odsc_host_model.sv */
// Host model driving the three-wire link and recording the chain output
`timescale 1ns/1ps
module odsc_host_model (
   output logic sclk,   // Link serial clock, still between frames
   output logic sync_n, // Frame strobe, active low
   output logic sdin,   // Serial data in
   input wire sdout     // Chain data out of the device
);
   logic echo[$];

   // Idle levels
   initial begin
      sclk = 1'h0;
      sync_n = 1'h1;
      sdin = 1'h0;
   end

   // shift bits MSB first at 6.25 MHz
   task automatic frame(input logic [31:0] w, input int n);
      #3;
      sync_n <= 1'h0;
      #80;
      for (int i = n - 1; i >= 0; i--) begin
         sdin <= w[i];
         sclk <= 1'h1;
         #80;
         sclk <= 1'h0;
         #80;
         echo.push_back(sdout);
      end
      sync_n <= 1'h1;
      sdin <= ~sdin;
      #400;
   endtask
endmodule // odsc_host_model

/* tb/octal_dac_serial_command_decoder_tb.sv */
// Self-checking bench for the octal converter serial command decoder
`timescale 1ns/1ps
`include "odsc_defines.vh"
module octal_dac_serial_command_decoder_tb;
   logic aclk;
   logic aresetn = 1'h0;
   wire sclk, sync_n, sdin, sdout, bias_shutdown;
   wire [95:0] dac_code;
   wire [7:0] pd_mask;
   wire [15:0] pd_term;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int miscompares = 0;
   int checked = 0;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [11:0] code_m[8] = '{default: 12'h0};
   logic [11:0] lat_m[8] = '{default: 12'h0};
   logic [1:0] term_m[8] = '{default: 2'h0};
   logic wt_m = 1'h0;
   logic [31:0] s;
   logic [15:0] dir[16] = '{16'h0ABC, 16'h7FFF, 16'h9000, 16'h3123, 16'h8000, 16'hA0F9,
      16'hB456, 16'h9000, 16'hC789, 16'hD0FF, 16'h2555, 16'hA001, 16'hE00F, 16'hF0F0,
      16'h8000, 16'h6AAA};

   odsc_top u_dut (.aclk, .aresetn, .sclk, .sync_n, .sdin, .sdout, .dac_code, .pd_mask,
      .pd_term, .bias_shutdown, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   odsc_host_model u_host (.sclk, .sync_n, .sdin, .sdout);

   // ------------------------------------------------------------
   // Clock, compare and verdict
   // ------------------------------------------------------------
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // AXI4-Lite master
   // ------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ap, wp;
      ap = 1'h1;
      wp = 1'h1;
      @(posedge aclk);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (ap || wp) begin
         @(posedge aclk);
         if (ap && s_axi_awready === 1'h1) begin
            ap = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (wp && s_axi_wready === 1'h1) begin
            wp = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      rq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
   endtask

   // Answers compared against the oldest note
   always @(posedge aclk) begin : resp_watch
      logic [33:0] e;
      if (s_axi_bvalid && s_axi_bready) begin
         cmp(32'(s_axi_bresp), 32'(bq.pop_front()), "write response");
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         cmp(s_axi_rdata, e[31:0], "read data");
         cmp(32'(s_axi_rresp), 32'(e[33:32]), "read response");
      end
   end

   // ------------------------------------------------------------
   // Reference model and scenarios
   // ------------------------------------------------------------
   function automatic void apply(input logic [15:0] w);
      logic [3:0] n;
      n = w[15:12];
      if (!w[15]) begin
         code_m[w[14:12]] = w[11:0];
         if (wt_m) begin
            lat_m[w[14:12]] = w[11:0];
            term_m[w[14:12]] = 2'h0;
         end
      end else if (n == `ODSC_CMD_REG_ONLY || n == `ODSC_CMD_WRITE_THRU) begin
         wt_m = n[0];
      end else begin
         for (int i = 0; i < 8; i++) begin
            if ((n == `ODSC_CMD_UPD_SELECT && w[i]) || n == `ODSC_CMD_CHA_WRITE ||
                n == `ODSC_CMD_BROADCAST) begin
               if (n == `ODSC_CMD_BROADCAST || (n == `ODSC_CMD_CHA_WRITE && i == 0)) begin
                  code_m[i] = w[11:0];
               end
               lat_m[i] = code_m[i];
               term_m[i] = 2'h0;
            end
            if (n >= `ODSC_CMD_PD_HIZ && w[i]) begin
               term_m[i] = n[1:0];
            end
         end
      end
   endfunction

   task automatic check_all();
      logic [7:0] pdm;
      for (int i = 0; i < 8; i++) begin
         pdm[i] = term_m[i] != 2'h0;
         cmp(32'(dac_code[12*i +: 12]), 32'(lat_m[i]), "latch");
         cmp(32'(pd_term[2*i +: 2]), 32'(term_m[i]), "termination");
         axi_rd(8'h20 + 8'(4 * i), 32'(code_m[i]), `ODSC_RESP_OKAY);
      end
      cmp(32'(bias_shutdown), 32'(pdm == 8'hFF), "bias shutdown");
      cmp(32'(pd_mask), 32'(pdm), "power-down mask");
      axi_rd(`ODSC_A_STATUS, {16'h0, pdm, 5'h0, 1'h0, pdm == 8'hFF, wt_m}, 2'h0);
   endtask

   task automatic run(input logic [15:0] w);
      u_host.frame({16'h0, w}, 16);
      apply(w);
      check_all();
   endtask

   initial begin
      void'($urandom(27822));
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (5) @(posedge aclk);
      axi_rd(`ODSC_A_CTRL, 32'h1, `ODSC_RESP_OKAY);
      check_all();
      u_host.frame(32'h0000C123, 14);
      u_host.frame(32'h0000C123, 15);
      check_all();
      axi_rd(`ODSC_A_ABORTS, 32'h2, `ODSC_RESP_OKAY);
      foreach (dir[i]) begin
         run(dir[i]);
      end
      s = 32'hA5C31ABC;
      u_host.echo.delete();
      u_host.frame(s, 32);
      for (int k = 1; k <= 32; k++) begin
         cmp(32'(u_host.echo[k-1]), (k < 15) ? 0 : (k == 15) ? 1 : 32'(s[47-k]), "echo");
      end
      apply(s[15:0]);
      check_all();
      axi_wr(`ODSC_A_CTRL, 32'h0, `ODSC_RESP_OKAY);
      u_host.frame(32'h0000C5A5, 16);
      check_all();
      axi_wr(`ODSC_A_CTRL, 32'h1, `ODSC_RESP_OKAY);
      axi_wr(`ODSC_A_STATUS, 32'h0, `ODSC_RESP_SLVERR);
      axi_rd(8'h80, 32'h0, `ODSC_RESP_SLVERR);
      axi_wr(`ODSC_A_FRAMES, 32'h0, `ODSC_RESP_OKAY);
      axi_rd(`ODSC_A_FRAMES, 32'h0, `ODSC_RESP_OKAY);
      repeat (40) begin
         run(16'($urandom()));
      end
      axi_rd(`ODSC_A_FRAMES, 32'h28, `ODSC_RESP_OKAY);
      tally_and_finish();
   end

   // Hang guard
   initial begin
      #1ms;
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // octal_dac_serial_command_decoder_tb

bind odsc_top odsc_checker u_chk (.aclk, .aresetn, .sclk, .sync_n, .sdin, .sdout, .dac_code,
   .pd_mask, .pd_term, .bias_shutdown, .s_axi_awaddr, .s_axi_wdata, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
